// File: pkg/nce_defines.vh
/* Constants of the nibble execute unit: operation codes, states,
   register selects and field widths. Assumes the fetch side resolves
   every operand, including bit-manipulation addressing, into fields. */
// Overview of operation
// - Back-to-back immediate loads of one group: only the first acts.
// - Load an 8-bit immediate into accumulator pair or pointer pair.
// - Move a nibble between accumulator and memory at the pointer pair.
// - Move a nibble between accumulator and a direct address.
// - Pair moves use an even address for A and the next for X.
// - Swap accumulator with memory or with X, H or L.
// - Table read from page bits and accumulator pair into A and X.
// - A table read at a page's last byte uses the following page.
// - Add immediate or pointer nibble; skip on carry, carry kept.
// - Add pointer nibble plus carry; carry flag takes the carry out.
// - Add-immediate after add-with-carry: skipped on carry, else no skip.
// - AND, OR or XOR pointer nibble into the accumulator.
// - Rotate accumulator right through the carry flag.
// - Invert the accumulator, flags untouched.
// - Increment register or any direct nibble; skip on wrap to zero.
// - Decrement register; skip when the result is all ones.
// - Skip on register equal immediate or accumulator equal memory.
// - Set, clear, invert carry; skip when carry is one.
// - Direct bit set, clear, skip-if-one, skip-if-zero in low memory.
// - Same four bit operations through bit-manipulation addressing.
// - Test-and-clear skips on a one bit and clears that bit.
// - Carry takes carry AND the addressed bit.
`ifndef NCE_DEFINES_VH
`define NCE_DEFINES_VH
`define NCE_LD_A_IMM   6'h00
`define NCE_LD_XA_IMM  6'h01
`define NCE_LD_HL_IMM  6'h02
`define NCE_LD_A_HL    6'h03
`define NCE_ST_HL_A    6'h04
`define NCE_LD_A_MEM   6'h05
`define NCE_LD_XA_MEM  6'h06
`define NCE_ST_MEM_A   6'h07
`define NCE_ST_MEM_XA  6'h08
`define NCE_XCH_A_HL   6'h09
`define NCE_XCH_A_MEM  6'h0A
`define NCE_XCH_XA_MEM 6'h0B
`define NCE_XCH_A_REG  6'h0C
`define NCE_TABLE_RD   6'h0D
`define NCE_ADDS_IMM   6'h0E
`define NCE_ADDS_HL    6'h0F
`define NCE_ADD_WITH_CARRY_OP_HL    6'h10
`define NCE_AND_HL     6'h11
`define NCE_OR_HL      6'h12
`define NCE_XOR_HL     6'h13
`define NCE_ROTATE_RIGHT_CARRY_OP       6'h14
`define NCE_NOT_A      6'h15
`define NCE_INCREMENT_SKIP_OP_REG   6'h16
`define NCE_INCREMENT_SKIP_OP_MEM   6'h17
`define NCE_DECREMENT_SKIP_OP_REG   6'h18
`define NCE_SKE_IMM    6'h19
`define NCE_SKE_A_HL   6'h1A
`define NCE_SET_CY     6'h1B
`define NCE_CLR_CY     6'h1C
`define NCE_SKT_CY     6'h1D
`define NCE_NOT_CY     6'h1E
`define NCE_BSET_MEM   6'h1F
`define NCE_BCLR_MEM   6'h20
`define NCE_SKT_MEM    6'h21
`define NCE_SKF_MEM    6'h22
`define NCE_BSET_F     6'h23
`define NCE_BCLR_F     6'h24
`define NCE_SKT_F      6'h25
`define NCE_SKF_F      6'h26
`define NCE_TCLR_F     6'h27
`define NCE_AND_CY_F   6'h28
// Register selects
`define NCE_SEL_X      2'h0
`define NCE_SEL_A      2'h1
`define NCE_SEL_H      2'h2
`define NCE_SEL_L      2'h3
// Immediate-load groups
`define NCE_GRP_NONE   2'h0
`define NCE_GRP_ACC    2'h1
`define NCE_GRP_PTR    2'h2
// States
`define NCE_S_IDLE     3'h0
`define NCE_S_RD       3'h1
`define NCE_S_DAT      3'h2
`define NCE_S_WR       3'h3
`define NCE_S_ROM      3'h4
`define NCE_S_ROMD     3'h5
// Values and fields
`define NCE_NIB_ZERO   4'h0
`define NCE_NIB_ONES   4'hF
`define NCE_NIB_ONE    4'h1
`define NCE_BYTE_ZERO  8'h00
`define NCE_PAGE_LAST  8'hFF
`define NCE_PAGE_ONE   3'h1
`define NCE_LOW_ADDR   8'h3F
`define NCE_EVEN_ADDR  8'h3E
`define NCE_ADDR_STEP  8'h01
`define NCE_ROM_ZERO   11'h000
`endif

// File: hw/nce_execute_unit.v
/* Nibble CPU execute unit: accumulator, X, H, L, carry flag and the
   skip state, plus sequencing of data memory and table ROM accesses.
   Assumes a decoder hands over one resolved instruction at a time with
   i_op_valid while o_ready is high, and that memory and ROM return read
   data in the cycle after the cycle their read strobe is high. */
`include "nce_defines.vh"
module nce_execute_unit (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_op_valid,
  input  wire [5:0]  i_op_code,
  input  wire [7:0]  i_op_imm,
  input  wire [1:0]  i_op_bit,
  input  wire [1:0]  i_op_reg,
  input  wire [10:0] i_op_pc,
  output wire        o_ready,
  output reg         o_done_r,
  output reg         o_skip_r,
  output reg         o_skip_pend_r,
  output reg  [7:0]  o_mem_addr_r,
  output reg         o_mem_rd_r,
  output reg         o_mem_wr_r,
  output reg  [3:0]  o_mem_wdata_r,
  input  wire [3:0]  i_mem_rdata,
  output reg  [10:0] o_rom_addr_r,
  output reg         o_rom_rd_r,
  input  wire [7:0]  i_rom_data,
  output reg  [3:0]  o_acc_r,
  output reg  [3:0]  o_x_r,
  output reg  [3:0]  o_h_r,
  output reg  [3:0]  o_l_r,
  output reg         o_carry_r
);

  reg [2:0] state_r;
  reg [5:0] op_r;
  reg [1:0] bit_r;
  reg       second_r;
  reg       wr_skip_r;
  reg [1:0] grp_r;
  reg       add_with_carry_op_r;
  reg       add_with_carry_op_cy_r;

  // Decode of the offered instruction
  wire [1:0] grp_in = (i_op_code == `NCE_LD_A_IMM ||
                       i_op_code == `NCE_LD_XA_IMM) ? `NCE_GRP_ACC :
                      (i_op_code == `NCE_LD_HL_IMM) ? `NCE_GRP_PTR :
                      `NCE_GRP_NONE;
  wire stacked  = (grp_in != `NCE_GRP_NONE) && (grp_in == grp_r);
  wire adds_cut = (i_op_code == `NCE_ADDS_IMM) && add_with_carry_op_r && add_with_carry_op_cy_r;
  wire cancel   = o_skip_pend_r || stacked || adds_cut;
  wire [7:0] hl = {o_h_r, o_l_r};
  wire [7:0] direct = i_op_imm & `NCE_LOW_ADDR;
  wire [7:0] pair_base = i_op_imm & `NCE_EVEN_ADDR;
  wire [3:0] mask = `NCE_NIB_ONE << bit_r;
  wire [3:0] md = i_mem_rdata;
  wire [4:0] sum_imm = {1'b0, o_acc_r} + {1'b0, i_op_imm[3:0]};
  wire [4:0] sum_mem = {1'b0, o_acc_r} + {1'b0, md};
  wire [4:0] sum_cy  = sum_mem + {4'h0, o_carry_r};
  wire [3:0] md_inc  = md + `NCE_NIB_ONE;
  wire [2:0] page = (i_op_pc[7:0] == `NCE_PAGE_LAST) ?
                    i_op_pc[10:8] + `NCE_PAGE_ONE : i_op_pc[10:8];
  wire pair_op = (op_r == `NCE_LD_XA_MEM) || (op_r == `NCE_ST_MEM_XA) ||
                 (op_r == `NCE_XCH_XA_MEM);

  // Selected register, for increment, decrement, compare and exchange
  reg [3:0] reg_sel;
  always @* begin
    case (i_op_reg)
      `NCE_SEL_X: reg_sel = o_x_r;
      `NCE_SEL_A: reg_sel = o_acc_r;
      `NCE_SEL_H: reg_sel = o_h_r;
      default:    reg_sel = o_l_r;
    endcase
  end
  wire [3:0] reg_inc = reg_sel + `NCE_NIB_ONE;
  wire [3:0] reg_dec = reg_sel - `NCE_NIB_ONE;

  assign o_ready = (state_r == `NCE_S_IDLE);

  // Ends an instruction: one done pulse, skip pulse and pending skip
  task finish;
    input s;
    begin
      o_done_r      <= 1'b1;
      o_skip_r      <= s;
      o_skip_pend_r <= s;
      state_r       <= `NCE_S_IDLE;
    end
  endtask

  // Writes a value into the register named by the select field
  task put_reg;
    input [1:0] sel;
    input [3:0] v;
    begin
      case (sel)
        `NCE_SEL_X: o_x_r   <= v;
        `NCE_SEL_A: o_acc_r <= v;
        `NCE_SEL_H: o_h_r   <= v;
        default:    o_l_r   <= v;
      endcase
    end
  endtask

  // Starts a memory read or a memory write at the given address
  task mem_read;
    input [7:0] a;
    begin
      o_mem_addr_r <= a;
      o_mem_rd_r   <= 1'b1;
      state_r      <= `NCE_S_RD;
    end
  endtask
  task mem_write;
    input [7:0] a;
    input [3:0] v;
    input       s;
    begin
      o_mem_addr_r  <= a;
      o_mem_wdata_r <= v;
      o_mem_wr_r    <= 1'b1;
      wr_skip_r     <= s;
      state_r       <= `NCE_S_WR;
    end
  endtask

  // Sequencer and datapath; all effects of one instruction live here
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= `NCE_S_IDLE;
      op_r <= `NCE_LD_A_IMM;
      bit_r <= 2'h0;
      second_r <= 1'b0;
      wr_skip_r <= 1'b0;
      grp_r <= `NCE_GRP_NONE;
      add_with_carry_op_r <= 1'b0;
      add_with_carry_op_cy_r <= 1'b0;
      o_done_r <= 1'b0;
      o_skip_r <= 1'b0;
      o_skip_pend_r <= 1'b0;
      o_mem_addr_r <= `NCE_BYTE_ZERO;
      o_mem_rd_r <= 1'b0;
      o_mem_wr_r <= 1'b0;
      o_mem_wdata_r <= `NCE_NIB_ZERO;
      o_rom_addr_r <= `NCE_ROM_ZERO;
      o_rom_rd_r <= 1'b0;
      o_acc_r <= `NCE_NIB_ZERO;
      o_x_r <= `NCE_NIB_ZERO;
      o_h_r <= `NCE_NIB_ZERO;
      o_l_r <= `NCE_NIB_ZERO;
      o_carry_r <= 1'b0;
    end else begin
      o_done_r <= 1'b0;
      o_skip_r <= 1'b0;
      o_mem_rd_r <= 1'b0;
      o_mem_wr_r <= 1'b0;
      o_rom_rd_r <= 1'b0;
      case (state_r)
        `NCE_S_IDLE: if (i_op_valid) begin
          op_r <= i_op_code;
          bit_r <= i_op_bit;
          second_r <= 1'b0;
          // Group tracking follows every offered load, even a cancelled one
          grp_r <= grp_in;
          add_with_carry_op_r <= (i_op_code == `NCE_ADD_WITH_CARRY_OP_HL) && !cancel;
          if (cancel)
            finish(1'b0);
          else case (i_op_code)
            `NCE_LD_A_IMM: begin
              o_acc_r <= i_op_imm[3:0];
              finish(1'b0);
            end
            `NCE_LD_XA_IMM: begin
              {o_x_r, o_acc_r} <= i_op_imm;
              finish(1'b0);
            end
            `NCE_LD_HL_IMM: begin
              {o_h_r, o_l_r} <= i_op_imm;
              finish(1'b0);
            end
            `NCE_LD_A_HL, `NCE_XCH_A_HL, `NCE_ADDS_HL, `NCE_ADD_WITH_CARRY_OP_HL,
            `NCE_AND_HL, `NCE_OR_HL, `NCE_XOR_HL, `NCE_SKE_A_HL:
              mem_read(hl);
            `NCE_ST_HL_A: mem_write(hl, o_acc_r, 1'b0);
            `NCE_LD_A_MEM, `NCE_XCH_A_MEM, `NCE_BSET_MEM, `NCE_BCLR_MEM,
            `NCE_SKT_MEM, `NCE_SKF_MEM:
              mem_read(direct);
            `NCE_ST_MEM_A: mem_write(direct, o_acc_r, 1'b0);
            `NCE_LD_XA_MEM, `NCE_XCH_XA_MEM: mem_read(pair_base);
            `NCE_ST_MEM_XA: mem_write(pair_base, o_acc_r, 1'b0);
            `NCE_INCREMENT_SKIP_OP_MEM, `NCE_BSET_F, `NCE_BCLR_F, `NCE_SKT_F, `NCE_SKF_F,
            `NCE_TCLR_F, `NCE_AND_CY_F:
              mem_read(i_op_imm);
            `NCE_XCH_A_REG: begin
              // An A select would swap A with itself, so it is a no-op
              if (i_op_reg != `NCE_SEL_A) begin
                put_reg(i_op_reg, o_acc_r);
                o_acc_r <= reg_sel;
              end
              finish(1'b0);
            end
            `NCE_TABLE_RD: begin
              o_rom_addr_r <= {page, o_x_r, o_acc_r};
              o_rom_rd_r <= 1'b1;
              state_r <= `NCE_S_ROM;
            end
            `NCE_ADDS_IMM: begin
              o_acc_r <= sum_imm[3:0];
              finish(sum_imm[4] && !add_with_carry_op_r);
            end
            `NCE_ROTATE_RIGHT_CARRY_OP: begin
              {o_acc_r, o_carry_r} <= {o_carry_r, o_acc_r};
              finish(1'b0);
            end
            `NCE_NOT_A: begin
              o_acc_r <= ~o_acc_r;
              finish(1'b0);
            end
            `NCE_INCREMENT_SKIP_OP_REG: begin
              put_reg(i_op_reg, reg_inc);
              finish(reg_inc == `NCE_NIB_ZERO);
            end
            `NCE_DECREMENT_SKIP_OP_REG: begin
              put_reg(i_op_reg, reg_dec);
              finish(reg_dec == `NCE_NIB_ONES);
            end
            `NCE_SKE_IMM: finish(reg_sel == i_op_imm[3:0]);
            `NCE_SET_CY: begin
              o_carry_r <= 1'b1;
              finish(1'b0);
            end
            `NCE_CLR_CY: begin
              o_carry_r <= 1'b0;
              finish(1'b0);
            end
            `NCE_NOT_CY: begin
              o_carry_r <= ~o_carry_r;
              finish(1'b0);
            end
            `NCE_SKT_CY: finish(o_carry_r);
            default: finish(1'b0);
          endcase
        end
        // Read strobe cycle; data arrives in the next one
        `NCE_S_RD: state_r <= `NCE_S_DAT;
        `NCE_S_DAT: case (op_r)
          `NCE_LD_A_HL, `NCE_LD_A_MEM: begin
            o_acc_r <= md;
            finish(1'b0);
          end
          `NCE_LD_XA_MEM: if (second_r) begin
            o_x_r <= md;
            finish(1'b0);
          end else begin
            o_acc_r <= md;
            second_r <= 1'b1;
            mem_read(o_mem_addr_r + `NCE_ADDR_STEP);
          end
          `NCE_XCH_A_HL, `NCE_XCH_A_MEM: begin
            o_acc_r <= md;
            mem_write(o_mem_addr_r, o_acc_r, 1'b0);
          end
          `NCE_XCH_XA_MEM: if (second_r) begin
            o_x_r <= md;
            mem_write(o_mem_addr_r, o_x_r, 1'b0);
          end else begin
            o_acc_r <= md;
            mem_write(o_mem_addr_r, o_acc_r, 1'b0);
          end
          `NCE_ADDS_HL: begin
            o_acc_r <= sum_mem[3:0];
            finish(sum_mem[4]);
          end
          `NCE_ADD_WITH_CARRY_OP_HL: begin
            o_acc_r <= sum_cy[3:0];
            o_carry_r <= sum_cy[4];
            add_with_carry_op_cy_r <= sum_cy[4];
            finish(1'b0);
          end
          `NCE_AND_HL: begin
            o_acc_r <= o_acc_r & md;
            finish(1'b0);
          end
          `NCE_OR_HL: begin
            o_acc_r <= o_acc_r | md;
            finish(1'b0);
          end
          `NCE_XOR_HL: begin
            o_acc_r <= o_acc_r ^ md;
            finish(1'b0);
          end
          `NCE_SKE_A_HL: finish(o_acc_r == md);
          `NCE_INCREMENT_SKIP_OP_MEM:
            mem_write(o_mem_addr_r, md_inc,
                      md_inc == `NCE_NIB_ZERO);
          `NCE_BSET_MEM, `NCE_BSET_F:
            mem_write(o_mem_addr_r, md | mask, 1'b0);
          `NCE_BCLR_MEM, `NCE_BCLR_F:
            mem_write(o_mem_addr_r, md & ~mask, 1'b0);
          `NCE_SKT_MEM, `NCE_SKT_F: finish(md[bit_r]);
          `NCE_SKF_MEM, `NCE_SKF_F: finish(!md[bit_r]);
          `NCE_TCLR_F:
            // Skip and clear come from the same read, so no bit is lost
            if (md[bit_r])
              mem_write(o_mem_addr_r, md & ~mask, 1'b1);
            else
              finish(1'b0);
          `NCE_AND_CY_F: begin
            o_carry_r <= o_carry_r & md[bit_r];
            finish(1'b0);
          end
          default: finish(1'b0);
        endcase
        // Write strobe cycle; pair operations continue with the high nibble
        `NCE_S_WR: if (pair_op && !second_r) begin
          second_r <= 1'b1;
          if (op_r == `NCE_ST_MEM_XA)
            mem_write(o_mem_addr_r + `NCE_ADDR_STEP, o_x_r, 1'b0);
          else
            mem_read(o_mem_addr_r + `NCE_ADDR_STEP);
        end else
          finish(wr_skip_r);
        `NCE_S_ROM: state_r <= `NCE_S_ROMD;
        `NCE_S_ROMD: begin
          {o_x_r, o_acc_r} <= i_rom_data;
          finish(1'b0);
        end
        default: state_r <= `NCE_S_IDLE;
      endcase
    end
  end

endmodule

// File: test/nce_exec_checker.sv
/* Checker for the execute unit: timing and register effects.
   Assumes a bind onto nce_execute_unit ports. */
`include "nce_defines.vh"
module nce_exec_checker (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_op_valid,
  input wire logic [5:0]  i_op_code,
  input wire logic [1:0]  i_op_reg,
  input wire logic [10:0] i_op_pc,
  input wire logic        o_ready,
  input wire logic        o_done_r,
  input wire logic        o_skip_r,
  input wire logic        o_skip_pend_r,
  input wire logic        o_mem_rd_r,
  input wire logic        o_mem_wr_r,
  input wire logic [10:0] o_rom_addr_r,
  input wire logic        o_rom_rd_r,
  input wire logic [3:0]  o_acc_r,
  input wire logic [3:0]  o_x_r,
  input wire logic        o_carry_r
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire tk = o_ready && i_op_valid;
  wire ex = tk && !o_skip_pend_r;
  logic [10:0] tbl_r;
  // Table address expected from the take, page bumped at a page end
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) tbl_r <= 11'h000;
    else if (tk) tbl_r <= {i_op_pc[10:8] + {2'h0, &i_op_pc[7:0]},
                           o_x_r, o_acc_r};
  end
  a_done_bound: assert property (tk |-> ##[1:7] o_done_r)
    else $error("no completion");
  a_skip_marks: assert property (o_skip_r |-> o_done_r && o_skip_pend_r)
    else $error("skip without pending");
  a_skip_consume: assert property (tk && o_skip_pend_r |=> o_done_r &&
    !o_skip_pend_r && $stable(o_acc_r) && $stable(o_carry_r))
    else $error("skipped op changed state");
  a_rd_wr_excl: assert property (!(o_mem_rd_r && o_mem_wr_r))
    else $error("read and write together");
  a_not_acc: assert property (ex && i_op_code == `NCE_NOT_A |=>
    o_acc_r == ~$past(o_acc_r) && $stable(o_carry_r))
    else $error("complement wrong");
  a_rotate_cy: assert property (ex && i_op_code == `NCE_ROTATE_RIGHT_CARRY_OP |=>
    {o_acc_r, o_carry_r} == {$past(o_carry_r), $past(o_acc_r)})
    else $error("rotate wrong");
  a_carry_inv: assert property (ex && i_op_code == `NCE_NOT_CY |=>
    o_carry_r != $past(o_carry_r))
    else $error("carry not inverted");
  a_table_addr: assert property (ex && i_op_code == `NCE_TABLE_RD |->
    ##[1:2] (o_rom_rd_r && o_rom_addr_r == tbl_r))
    else $error("table address wrong");
  a_increment_skip_op_wrap: assert property (ex && i_op_code == `NCE_INCREMENT_SKIP_OP_REG &&
    i_op_reg == `NCE_SEL_A && o_acc_r == 4'hF |=> o_acc_r == 4'h0 && o_skip_r)
    else $error("increment wrap without skip");
endmodule

// File: test/nce_mem_model.sv
/* Data memory and table ROM seen by the execute unit.
   Read data is valid only in the cycle after a strobe; otherwise the
   inverse is shown so a late sample cannot pass by luck. */
module nce_mem_model (
  input  wire logic        i_clk,
  input  wire logic [7:0]  i_mem_addr,
  input  wire logic        i_mem_rd,
  input  wire logic        i_mem_wr,
  input  wire logic [3:0]  i_mem_wdata,
  output wire logic [3:0]  o_mem_rdata,
  input  wire logic [10:0] i_rom_addr,
  input  wire logic        i_rom_rd,
  output wire logic [7:0]  o_rom_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] mem_r [0:255];
  logic [3:0] rd_r = 4'h0;
  logic [7:0] rom_r = 8'h00;
  logic       rd_v_r = 1'b0;
  logic       rom_v_r = 1'b0;
  // ROM byte mixes page into the data so a wrong page shows
  always @(posedge i_clk) begin
    rd_v_r <= i_mem_rd;
    rom_v_r <= i_rom_rd;
    if (i_mem_rd) rd_r <= mem_r[i_mem_addr];
    if (i_mem_wr) mem_r[i_mem_addr] <= i_mem_wdata;
    if (i_rom_rd) rom_r <= {i_rom_addr[10:8], 5'h00} ^ i_rom_addr[7:0];
  end
  assign o_mem_rdata = rd_v_r ? rd_r : ~rd_r;
  assign o_rom_data = rom_v_r ? rom_r : ~rom_r;
endmodule

// File: test/nce_execute_unit_test.sv
/* Self-checking bench for the execute unit with memory model.
   Assumes the op codes of nce_defines.vh. */
`include "nce_defines.vh"
module nce_execute_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, skp;
  logic [5:0] code = 6'h00;
  logic [7:0] imm = 8'h00;
  logic [1:0] rsel = 2'h0, bsel = 2'h0;
  logic [10:0] pc = 11'h000;
  wire rdy, done, skip, pend, mrd, mwr, rrd, cy;
  wire [7:0] maddr, rdata;
  wire [10:0] raddr;
  wire [3:0] wdat, mdat, acc, x, h, l;
  int err_count = 0, n_checks = 0;
  always #10 clk = ~clk;
  nce_execute_unit i_nce_execute_unit (.i_clk(clk), .i_rst_n(rst_n),
    .i_op_valid(vld), .i_op_code(code), .i_op_imm(imm), .i_op_bit(bsel),
    .i_op_reg(rsel), .i_op_pc(pc), .o_ready(rdy), .o_done_r(done),
    .o_skip_r(skip), .o_skip_pend_r(pend), .o_mem_addr_r(maddr),
    .o_mem_rd_r(mrd), .o_mem_wr_r(mwr), .o_mem_wdata_r(wdat),
    .i_mem_rdata(mdat), .o_rom_addr_r(raddr), .o_rom_rd_r(rrd),
    .i_rom_data(rdata), .o_acc_r(acc), .o_x_r(x), .o_h_r(h), .o_l_r(l),
    .o_carry_r(cy));
  nce_mem_model i_nce_mem_model (.i_clk(clk), .i_mem_addr(maddr),
    .i_mem_rd(mrd), .i_mem_wr(mwr), .i_mem_wdata(wdat),
    .o_mem_rdata(mdat), .i_rom_addr(raddr), .i_rom_rd(rrd),
    .o_rom_data(rdata));
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One instruction offered at a falling edge, held until taken
  task automatic issue(input logic [5:0] c, input logic [7:0] m = 8'h00,
      input logic [1:0] r = 2'h0, b = 2'h0, input logic [10:0] p = 11'h0);
    int n;
    @(negedge clk);
    {vld, code, imm, rsel, bsel, pc} = {1'b1, c, m, r, b, p};
    for (n = 0; rdy !== 1'b1 && n < 20; n++) @(negedge clk);
    @(negedge clk);
    vld = 1'b0;
    for (n = 0; done !== 1'b1 && n < 20; n++) @(negedge clk);
    if (n >= 20) chk("done", 8'h01, 8'h00);
    skp = skip;
  endtask
  // Skip flag, then on an expected skip a filler op that must leave A untouched
  task automatic sk(input logic e);
    logic [3:0] a;
    a = acc;
    chk("skip", {7'h0, e}, {7'h0, skp});
    if (e) begin
      issue(`NCE_NOT_A);
      chk("held", {4'h0, a}, {4'h0, acc});
    end
  endtask
  task automatic t_loads;
    issue(`NCE_LD_A_IMM, 8'h05);
    issue(`NCE_LD_A_IMM, 8'h09);
    chk("acc", 8'h05, {4'h0, acc});
    issue(`NCE_LD_HL_IMM, 8'hFF);
    issue(`NCE_LD_HL_IMM, 8'h12);
    chk("hl", 8'hFF, {h, l});
    issue(`NCE_LD_XA_IMM, 8'h00);
    chk("xa", 8'h00, {x, acc});
  endtask
  task automatic t_mem;
    i_nce_mem_model.mem_r[8'h3E] = 4'h7;
    i_nce_mem_model.mem_r[8'h3F] = 4'hC;
    i_nce_mem_model.mem_r[8'h3C] = 4'h3;
    issue(`NCE_LD_HL_IMM, 8'h3E);
    issue(`NCE_LD_A_HL);
    chk("acc", 8'h07, {4'h0, acc});
    issue(`NCE_LD_XA_MEM, 8'h3E);
    chk("xa", 8'hC7, {x, acc});
    issue(`NCE_NOT_A);
    issue(`NCE_ST_HL_A);
    chk("m3e", 8'h08, {4'h0, i_nce_mem_model.mem_r[8'h3E]});
    issue(`NCE_ST_MEM_XA, 8'h20);
    chk("m20", 8'hC8, {i_nce_mem_model.mem_r[8'h21],
                       i_nce_mem_model.mem_r[8'h20]});
    issue(`NCE_XCH_A_MEM, 8'h3F);
    chk("xch", 8'hC8, {acc, i_nce_mem_model.mem_r[8'h3F]});
    issue(`NCE_XCH_A_REG, 8'h00, `NCE_SEL_L);
    chk("xchl", 8'hEC, {acc, l});
    issue(`NCE_LD_A_MEM, 8'h20);
    chk("acc", 8'h08, {4'h0, acc});
    issue(`NCE_ST_MEM_A, 8'h05);
    chk("m05", 8'h08, {4'h0, i_nce_mem_model.mem_r[8'h05]});
    issue(`NCE_LD_XA_IMM, 8'h5A);
    issue(`NCE_XCH_XA_MEM, 8'h3E);
    chk("xxa", 8'h88, {x, acc});
    chk("mxa", 8'h5A, {i_nce_mem_model.mem_r[8'h3F],
                       i_nce_mem_model.mem_r[8'h3E]});
    issue(`NCE_XCH_A_HL);
    chk("xhl", 8'h38, {acc, i_nce_mem_model.mem_r[8'h3C]});
  endtask
  task automatic t_table;
    issue(`NCE_LD_XA_IMM, 8'h5A);
    issue(`NCE_TABLE_RD, 8'h00, 2'h0, 2'h0, 11'h2FF);
    chk("page", 8'h3A, {x, acc});
    issue(`NCE_TABLE_RD, 8'h00, 2'h0, 2'h0, 11'h2FE);
    chk("tbl", 8'h7A, {x, acc});
  endtask
  task automatic t_arith;
    i_nce_mem_model.mem_r[8'h30] = 4'h9;
    issue(`NCE_LD_A_IMM, 8'h0E);
    issue(`NCE_ADDS_IMM, 8'h03);
    chk("cy", 8'h01, {cy, acc});
    sk(1'b1);
    issue(`NCE_LD_HL_IMM, 8'h30);
    issue(`NCE_LD_A_IMM, 8'h08);
    issue(`NCE_SET_CY);
    issue(`NCE_ADD_WITH_CARRY_OP_HL);
    chk("add_with_carry_op", 8'h12, {3'h0, cy, acc});
    issue(`NCE_ADDS_IMM, 8'h06);
    chk("corr", 8'h02, {4'h0, acc});
    issue(`NCE_CLR_CY);
    issue(`NCE_LD_A_IMM, 8'h04);
    issue(`NCE_ADD_WITH_CARRY_OP_HL);
    issue(`NCE_ADDS_IMM, 8'h06);
    chk("nosk", 8'h03, {3'h0, cy, acc});
    sk(1'b0);
    issue(`NCE_SET_CY);
    issue(`NCE_ADDS_HL);
    chk("addh", 8'h1C, {3'h0, cy, acc});
    sk(1'b0);
    issue(`NCE_ADDS_HL);
    chk("addh", 8'h15, {3'h0, cy, acc});
    sk(1'b1);
  endtask
  task automatic t_logic;
    issue(`NCE_LD_A_IMM, 8'h0C);
    issue(`NCE_AND_HL);
    chk("and", 8'h08, {4'h0, acc});
    issue(`NCE_OR_HL);
    chk("or", 8'h09, {4'h0, acc});
    issue(`NCE_XOR_HL);
    chk("xor", 8'h00, {4'h0, acc});
    issue(`NCE_LD_A_IMM, 8'h05);
    issue(`NCE_SET_CY);
    issue(`NCE_ROTATE_RIGHT_CARRY_OP);
    chk("rot", 8'h1A, {3'h0, cy, acc});
    issue(`NCE_NOT_A);
    chk("not", 8'h15, {3'h0, cy, acc});
    issue(`NCE_NOT_CY);
    issue(`NCE_SKT_CY);
    sk(1'b0);
    issue(`NCE_NOT_CY);
    issue(`NCE_SKT_CY);
    sk(1'b1);
  endtask
  task automatic t_incdec;
    i_nce_mem_model.mem_r[8'hC0] = 4'hF;
    issue(`NCE_LD_A_IMM, 8'h0F);
    issue(`NCE_INCREMENT_SKIP_OP_REG, 8'h00, `NCE_SEL_A);
    sk(1'b1);
    issue(`NCE_DECREMENT_SKIP_OP_REG, 8'h00, `NCE_SEL_A);
    chk("dec", 8'h0F, {4'h0, acc});
    sk(1'b1);
    issue(`NCE_INCREMENT_SKIP_OP_MEM, 8'hC0);
    chk("mc0", 8'h00, {4'h0, i_nce_mem_model.mem_r[8'hC0]});
    sk(1'b1);
    issue(`NCE_SKE_IMM, 8'h00, `NCE_SEL_A);
    sk(1'b0);
    issue(`NCE_SKE_IMM, 8'h0F, `NCE_SEL_A);
    sk(1'b1);
    issue(`NCE_SKE_A_HL);
    sk(1'b0);
  endtask
  task automatic t_bits;
    i_nce_mem_model.mem_r[8'h3F] = 4'h0;
    i_nce_mem_model.mem_r[8'hF3] = 4'h8;
    issue(`NCE_BSET_MEM, 8'h3F, 2'h0, 2'h2);
    chk("set", 8'h04, {4'h0, i_nce_mem_model.mem_r[8'h3F]});
    issue(`NCE_SKT_MEM, 8'h3F, 2'h0, 2'h2);
    sk(1'b1);
    issue(`NCE_SKF_MEM, 8'h3F, 2'h0, 2'h1);
    sk(1'b1);
    issue(`NCE_BCLR_MEM, 8'h3F, 2'h0, 2'h2);
    chk("clr", 8'h00, {4'h0, i_nce_mem_model.mem_r[8'h3F]});
    issue(`NCE_TCLR_F, 8'hF3, 2'h0, 2'h3);
    chk("tclr", 8'h00, {4'h0, i_nce_mem_model.mem_r[8'hF3]});
    sk(1'b1);
    issue(`NCE_BSET_F, 8'hF3, 2'h0, 2'h0);
    issue(`NCE_SKT_F, 8'hF3, 2'h0, 2'h0);
    sk(1'b1);
    issue(`NCE_SKF_F, 8'hF3, 2'h0, 2'h0);
    sk(1'b0);
    issue(`NCE_SET_CY);
    issue(`NCE_AND_CY_F, 8'hF3, 2'h0, 2'h1);
    chk("carry_bit_and_op", 8'h00, {7'h0, cy});
    issue(`NCE_SET_CY);
    issue(`NCE_AND_CY_F, 8'hF3, 2'h0, 2'h0);
    chk("carry_bit_and_op", 8'h01, {7'h0, cy});
    issue(`NCE_BCLR_F, 8'hF3, 2'h0, 2'h0);
    chk("fclr", 8'h00, {4'h0, i_nce_mem_model.mem_r[8'hF3]});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog: about 100 ops of under 10 cycles fit well in 4000 cycles
  initial begin
    #80000;
    err_count++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_loads();
    t_mem();
    t_table();
    t_arith();
    t_logic();
    t_incdec();
    t_bits();
    test_done();
  end
endmodule
bind nce_execute_unit nce_exec_checker i_nce_exec_checker (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_op_valid(i_op_valid), .i_op_code(i_op_code),
  .i_op_reg(i_op_reg), .i_op_pc(i_op_pc), .o_ready(o_ready),
  .o_done_r(o_done_r), .o_skip_r(o_skip_r), .o_skip_pend_r(o_skip_pend_r),
  .o_mem_rd_r(o_mem_rd_r), .o_mem_wr_r(o_mem_wr_r),
  .o_rom_addr_r(o_rom_addr_r), .o_rom_rd_r(o_rom_rd_r),
  .o_acc_r(o_acc_r), .o_x_r(o_x_r), .o_carry_r(o_carry_r));
